// [hdl/fic_pkg.sv]
// package: constants and carrier types for the fifo interrupt and clear logic
package fic_pkg;

  // interrupt pin selector codes
  localparam logic [1:0] FIC_PIN_DEDICATED = 2'h0;
  localparam logic [1:0] FIC_PIN_CLOCK     = 2'h1;
  localparam logic [1:0] FIC_PIN_GPO_TWO   = 2'h2;

  // threshold compare field of a conversion result
  localparam int FIC_CMP_MSB = 23;
  localparam int FIC_CMP_LSB = 12;
  localparam int FIC_CMP_W   = FIC_CMP_MSB - FIC_CMP_LSB + 1;
  // release margin above low / below high once a limit flag is set
  localparam logic [FIC_CMP_W:0] FIC_HYST_MARGIN = 13'h0002;

  // fifo depth and watermark
  localparam int FIC_DEPTH_W = 9;
  localparam logic [FIC_DEPTH_W-1:0] FIC_FULL_DEPTH = 9'h100;

  // reset values
  localparam logic FIC_RST_EN_OFF      = 1'b0;
  localparam logic FIC_RST_WM_EN       = 1'b1;
  localparam logic FIC_RST_IRQ         = 1'b0;

  // per-source interrupt enables
  typedef struct packed {
    logic upper_limit_irq_enable;
    logic lower_limit_irq_enable;
    logic watermark_irq_enable;
    logic empty_irq_enable;
    logic write_err_irq_enable;
    logic read_err_irq_enable;
    logic overrun_irq_enable;
  } fic_enables_s;

  // fifo status conditions from the storage side
  typedef struct packed {
    logic empty;
    logic write_err;
    logic read_err;
    logic overrun;
    logic [FIC_DEPTH_W-1:0] level;
  } fic_fifo_status_s;

  // pin routing outputs
  typedef struct packed {
    logic dedicated_irq;
    logic clock_pin_irq;
    logic clock_pin_irq_oe;
    logic pin_two_out;
    logic pin_two_oe;
  } fic_pins_s;

endpackage

// [hdl/fic_irq_logic.sv]
// module: fifo interrupt sources, pin routing and fifo clear generation
//
// Function
// - upper/lower limit flags each have enables
// - control write with fifo on clears limit flags and their irq
// - limit flags release with two lsb hysteresis
// - empty raises irq when enabled, clears on write
// - write/read errors have separate enables
// - overrun irq enabled separately, clears when emptied
// - selector routes irq to dedicated, clock, pin two
// - selected pin ignores its other controls
// - pin two irq keeps gpos on in standby
// - fifo disabled routes conversion ready instead
// - any control write empties enabled fifo
// - frame pin flush clears fifo, restarts sequencer
// - interrupt is or of enabled sources
// - watermark irq default on, zero means 256
module fic_irq_logic
  import fic_pkg::*;
(
  input  wire logic                   clock,                 // master clock, 250 MHz
  input  wire logic                   rst,                   // async reset, active high
  input  wire logic                   fifo_enable,           // fifo in use
  input  wire logic                   ctrl_write,            // pulse: fifo control register written
  input  wire fic_enables_s           ctrl_enables,          // enables carried by that write
  input  wire logic [7:0]             watermark,             // watermark field carried by that write
  input  wire logic                   bipolar,               // output coding, compare as signed
  input  wire logic [FIC_CMP_W-1:0]   upper_limit_value,     // high threshold
  input  wire logic [FIC_CMP_W-1:0]   lower_limit_value,     // low threshold
  input  wire logic                   result_valid,          // pulse: result written to fifo
  input  wire logic                   result_limit_check,    // channel has threshold check on
  input  wire logic [23:0]            result_data,           // conversion result
  input  wire logic                   fifo_drained,          // pulse: all content read out
  input  wire fic_fifo_status_s       fifo_status,           // storage-side status
  input  wire logic                   conv_ready,            // conversion ready level
  input  wire logic [1:0]             int_pin_sel,           // interrupt pin selector
  input  wire logic                   frame_pin_flush_enable,// sync pin clears fifo
  input  wire logic                   frame_sync_n,          // frame sync pin, active low
  input  wire logic                   ext_clock_select,      // clock pin used as clock input
  input  wire logic                   pin_two_output_control,// gpo drive of pin two
  input  wire logic                   pin_two_gpo_level,     // gpo level for pin two
  input  wire logic                   standby,               // device in standby
  input  wire logic                   gpo_enable,            // software gpo enable
  output fic_enables_s                enables,               // registered enables
  output logic                        upper_limit_hit,       // sticky high flag
  output logic                        lower_limit_hit,       // sticky low flag
  output logic                        watermark_hit,         // watermark flag
  output logic                        fifo_irq,              // combined interrupt level
  output logic                        fifo_clear,            // pulse: empty the fifo
  output logic                        sequencer_restart,     // pulse: restart at first channel
  output logic                        clock_input_active,    // clock pin acts as clock input
  output logic                        gpo_standby_keep,      // gpos kept on in standby
  output fic_pins_s                   pins                   // routed pin outputs
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // widen a compare field to a signed-safe offset form
  function automatic logic [FIC_CMP_W:0] fic_key(input logic [FIC_CMP_W-1:0] v, input logic sgn);
    fic_key = {1'b0, v[FIC_CMP_W-1] ^ sgn, v[FIC_CMP_W-2:0]};
  endfunction

  logic [7:0]             wm_value;
  logic                   sync_q;
  logic                   flush_event;
  logic [FIC_CMP_W:0]     res_key;
  logic [FIC_CMP_W:0]     hi_key;
  logic [FIC_CMP_W:0]     lo_key;
  logic                   above_hi;
  logic                   below_lo;
  logic                   hi_release;
  logic                   lo_release;
  logic                   irq_src;
  logic                   irq_sel;
  logic [FIC_DEPTH_W-1:0] wm_need;

  ////////////////////////////////////////////////////////////////////////////
  // enables and watermark, latched from control writes

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      enables <= '{upper_limit_irq_enable: FIC_RST_EN_OFF, lower_limit_irq_enable: FIC_RST_EN_OFF,
                   watermark_irq_enable: FIC_RST_WM_EN, empty_irq_enable: FIC_RST_EN_OFF,
                   write_err_irq_enable: FIC_RST_EN_OFF, read_err_irq_enable: FIC_RST_EN_OFF,
                   overrun_irq_enable: FIC_RST_EN_OFF};
      wm_value <= 8'h00;
    end else if (ctrl_write) begin
      enables  <= ctrl_enables;
      wm_value <= watermark;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo clear sources

  // edge of frame sync; pin treated as synchronous, one stage for the edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b1;
    end else begin
      sync_q <= frame_sync_n;
    end
  end

  assign flush_event = frame_pin_flush_enable && sync_q && !frame_sync_n;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_clear        <= 1'b0;
      sequencer_restart <= 1'b0;
    end else begin
      fifo_clear        <= (fifo_enable && ctrl_write) || flush_event;
      sequencer_restart <= flush_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold compare with hysteresis

  // limits come pre-coded by the host to match bipolar; compare in offset form
  assign res_key  = fic_key(result_data[FIC_CMP_MSB:FIC_CMP_LSB], bipolar);
  assign hi_key   = fic_key(upper_limit_value, bipolar);
  assign lo_key   = fic_key(lower_limit_value, bipolar);
  assign above_hi = res_key > hi_key;
  assign below_lo = res_key < lo_key;
  assign hi_release = (res_key + FIC_HYST_MARGIN) <= hi_key;
  assign lo_release = res_key >= (lo_key + FIC_HYST_MARGIN);

  // clear on control write, sync flush or drain; a clear wins over a set from a result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upper_limit_hit <= 1'b0;
      lower_limit_hit <= 1'b0;
    end else if ((fifo_enable && ctrl_write) || flush_event || fifo_drained) begin
      upper_limit_hit <= 1'b0;
      lower_limit_hit <= 1'b0;
    end else if (result_valid && result_limit_check) begin
      upper_limit_hit <= above_hi || (upper_limit_hit && !hi_release);
      lower_limit_hit <= below_lo || (lower_limit_hit && !lo_release);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watermark and combined interrupt

  assign wm_need = (wm_value == 8'h00) ? FIC_FULL_DEPTH : {1'b0, wm_value};
  assign watermark_hit = fifo_status.level >= wm_need;

  always_comb begin
    irq_src = 1'b0;
    irq_src = irq_src | (enables.upper_limit_irq_enable & upper_limit_hit);
    irq_src = irq_src | (enables.lower_limit_irq_enable & lower_limit_hit);
    irq_src = irq_src | (enables.watermark_irq_enable & watermark_hit);
    irq_src = irq_src | (enables.empty_irq_enable & fifo_status.empty);
    irq_src = irq_src | (enables.write_err_irq_enable & fifo_status.write_err);
    irq_src = irq_src | (enables.read_err_irq_enable & fifo_status.read_err);
    irq_src = irq_src | (enables.overrun_irq_enable & fifo_status.overrun);
  end

  assign irq_sel = fifo_enable ? irq_src : conv_ready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_irq <= FIC_RST_IRQ;
    end else begin
      fifo_irq <= irq_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin routing

  // interrupt overrides clock input and gpo control
  always_comb begin
    pins.dedicated_irq    = (int_pin_sel == FIC_PIN_DEDICATED) && fifo_irq;
    pins.clock_pin_irq    = (int_pin_sel == FIC_PIN_CLOCK) && fifo_irq;
    pins.clock_pin_irq_oe = int_pin_sel == FIC_PIN_CLOCK;
    if (int_pin_sel == FIC_PIN_GPO_TWO) begin
      pins.pin_two_out = fifo_irq;
      pins.pin_two_oe  = 1'b1;
    end else begin
      pins.pin_two_out = pin_two_gpo_level;
      pins.pin_two_oe  = pin_two_output_control;
    end
  end

  assign clock_input_active = ext_clock_select && (int_pin_sel != FIC_PIN_CLOCK);

  assign gpo_standby_keep = gpo_enable || (standby && (int_pin_sel == FIC_PIN_GPO_TWO));

endmodule

// [verification/fic_props.sv]
// checker: port-level properties of the fifo interrupt and clear logic
module fic_props
  import fic_pkg::*;
(
  input wire logic             clock,                  // clock
  input wire logic             rst,                    // reset
  input wire logic             fifo_enable,            // fifo on
  input wire logic             ctrl_write,             // write
  input wire logic             frame_pin_flush_enable, // sync flush
  input wire logic             frame_sync_n,           // sync pin
  input wire logic [1:0]       int_pin_sel,            // selector
  input wire logic             conv_ready,             // ready
  input wire fic_fifo_status_s fifo_status,            // status
  input wire fic_enables_s     enables,                // enables
  input wire logic             upper_limit_hit,        // high flag
  input wire logic             lower_limit_hit,        // low flag
  input wire logic             fifo_irq,               // irq
  input wire logic             fifo_clear,             // clear
  input wire logic             sequencer_restart,      // restart
  input wire logic             clock_input_active,     // clock in
  input wire logic             gpo_standby_keep,       // gpos kept
  input wire logic             standby,                // standby mode
  input wire fic_pins_s        pins                    // pins
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // clearing: a write clears only while the fifo is on
  wr_flush_a: assert property (fifo_enable && ctrl_write |=> fifo_clear) else $error("no clear after write");
  wr_flags_a: assert property (fifo_enable && ctrl_write |=> !upper_limit_hit && !lower_limit_hit)
    else $error("limit flag kept after write");
  off_write_a: assert property (!fifo_enable && ctrl_write && !frame_pin_flush_enable |=> !fifo_clear)
    else $error("clear while fifo off");
  sync_flush_a: assert property (frame_pin_flush_enable && $fell(frame_sync_n) |=> fifo_clear && sequencer_restart)
    else $error("sync pin gave no flush");
  // irq is registered, so it follows its sources one cycle late
  // with the fifo off the ready level is routed instead, so only fifo-on cycles count
  empty_irq_a: assert property (fifo_enable && !ctrl_write && enables.empty_irq_enable && fifo_status.empty |=> fifo_irq)
    else $error("empty irq missing");
  quiet_irq_a: assert property (fifo_enable && !ctrl_write && enables == 7'h00 |=> !fifo_irq)
    else $error("irq with no enable");
  // routing is combinational, checked in the same cycle
  two_route_a: assert property (fifo_enable && int_pin_sel == FIC_PIN_GPO_TWO |->
    pins.pin_two_out == fifo_irq && pins.pin_two_oe && (!standby || gpo_standby_keep)) else $error("pin two routing wrong");
  clk_route_a: assert property (fifo_enable && int_pin_sel == FIC_PIN_CLOCK |->
    pins.clock_pin_irq == fifo_irq && pins.clock_pin_irq_oe && !clock_input_active) else $error("clock pin wrong");
  ded_route_a: assert property (int_pin_sel == FIC_PIN_DEDICATED |->
    pins.dedicated_irq == (fifo_enable ? fifo_irq : conv_ready)) else $error("dedicated pin wrong");
endmodule
bind fic_irq_logic fic_props u_fic_props (.clock, .rst, .fifo_enable, .ctrl_write, .frame_pin_flush_enable,
  .frame_sync_n, .int_pin_sel, .conv_ready, .fifo_status, .enables, .upper_limit_hit, .lower_limit_hit,
  .fifo_irq, .fifo_clear, .sequencer_restart, .clock_input_active, .gpo_standby_keep, .standby, .pins);

// [verification/fic_host_model.sv]
// host model: threshold programming and the flush that follows it
module fic_host_model
  import fic_pkg::*;
(
  input  wire logic                 clock,             // clock
  input  wire logic                 rst,               // reset
  input  wire logic                 load,              // new limits
  input  wire logic [FIC_CMP_W-1:0] upper_in,          // high value
  input  wire logic [FIC_CMP_W-1:0] lower_in,          // low value
  output logic      [FIC_CMP_W-1:0] upper_limit_value, // held high
  output logic      [FIC_CMP_W-1:0] lower_limit_value, // held low
  output logic                      bipolar,           // coding
  output logic                      flush_req          // control write
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // unipolar coding chosen
  assign bipolar = 1'b0;
  // flush after change, so old flags do not mix with new limits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upper_limit_value <= 12'hFFF;
      lower_limit_value <= 12'h000;
      flush_req         <= 1'b0;
    end else begin
      if (load) begin
        upper_limit_value <= upper_in;
        lower_limit_value <= lower_in;
      end
      flush_req <= load;
    end
  end
endmodule

// [verification/testbench.sv]
// testbench: directed checks of the fifo interrupt and clear logic
module testbench
  import fic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst, fifo_enable, wr, load, result_valid, result_limit_check, conv_ready, frame_pin_flush_enable;
  logic frame_sync_n, oth, fifo_irq, fifo_clear, sequencer_restart, clock_input_active, gpo_standby_keep;
  logic flush_req, upper_limit_hit, lower_limit_hit, bipolar, clr_seen, seen, wm_hit;
  logic             [1:0]  int_pin_sel;
  logic             [11:0] upper_limit_value, lower_limit_value, up_in, lo_in;
  logic             [23:0] result_data;
  fic_enables_s            en, enables;
  fic_fifo_status_s        fifo_status;
  fic_pins_s               pins;
  int                      failures, n_compared;
  fic_irq_logic u_fic_irq_logic (
    .clock, .rst, .fifo_enable, .ctrl_write(wr | flush_req), .ctrl_enables(en), .watermark(8'h00),
    .bipolar, .upper_limit_value, .lower_limit_value, .result_valid, .result_limit_check, .result_data,
    .fifo_drained(1'b0), .fifo_status, .conv_ready, .int_pin_sel, .frame_pin_flush_enable, .frame_sync_n,
    .ext_clock_select(oth), .pin_two_output_control(oth), .pin_two_gpo_level(1'b0), .standby(oth),
    .gpo_enable(1'b0), .enables, .upper_limit_hit, .lower_limit_hit, .watermark_hit(wm_hit), .fifo_irq,
    .fifo_clear, .sequencer_restart, .clock_input_active, .gpo_standby_keep, .pins);
  fic_host_model u_fic_host_model (.clock, .rst, .load, .upper_in(up_in), .lower_in(lo_in),
    .upper_limit_value, .lower_limit_value, .bipolar, .flush_req);
  ////////////////////////////////////////////////////////////
  // free-running clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // comparison and pacing helpers
  task automatic cmp(input string name, input logic [12:0] exp, input logic [12:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // control write: clear pulse is sampled right after the taking edge
  task automatic ctrl(input logic [6:0] e);
    @(posedge clock);
    en <= e;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1 clr_seen = fifo_clear;
    tick(2);
  endtask
  task automatic result(input logic [11:0] v);
    @(posedge clock);
    result_valid <= 1'b1;
    result_data  <= {v, 12'h000};
    @(posedge clock);
    result_valid <= 1'b0;
    tick(2);
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, frame_sync_n} = 2'b11;
    {fifo_enable, wr, load, result_valid, result_limit_check, conv_ready, frame_pin_flush_enable, oth} = '0;
    {int_pin_sel, up_in, lo_in, result_data, en, fifo_status, failures, n_compared} = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    tick(1);
    cmp("reset enables", 13'h10, enables);
    cmp("reset irq", 0, fifo_irq);
    $display("test reset done");
    fifo_enable <= 1'b1;
    result_limit_check <= 1'b1;
    ctrl(7'h40);
    cmp("write clears", 1, clr_seen);
    @(posedge clock);
    {up_in, lo_in, load} <= {12'h800, 12'h100, 1'b1};
    @(posedge clock);
    load <= 1'b0;
    tick(3);
    result(12'h900);
    cmp("upper irq", 3, {upper_limit_hit, fifo_irq});
    result(12'h7FF);
    cmp("hysteresis hold", 1, upper_limit_hit);
    result(12'h7FE);
    cmp("hysteresis release", 0, upper_limit_hit);
    result(12'h0FF);
    cmp("lower masked", 2, {lower_limit_hit, fifo_irq});
    result(12'h900);
    ctrl(7'h40);
    cmp("write clears flags", 0, {upper_limit_hit, lower_limit_hit, fifo_irq});
    $display("test limits done");
    for (int i = 0; i < 4; i++) begin
      ctrl(7'h00);
      @(posedge clock);
      fifo_status <= 13'h1000 >> i;
      tick(2);
      cmp("masked source", 0, fifo_irq);
      ctrl(7'h08 >> i);
      cmp("enabled source", 1, fifo_irq);
      @(posedge clock);
      fifo_status <= '0;
      tick(2);
      cmp("source cleared", 0, fifo_irq);
    end
    ctrl(7'h10);
    @(posedge clock);
    fifo_status <= 13'h00FF;
    tick(2);
    cmp("watermark below", 0, fifo_irq);
    cmp("watermark flag low", 0, wm_hit);
    @(posedge clock);
    fifo_status <= 13'h0100;
    tick(2);
    cmp("watermark full", 1, fifo_irq);
    cmp("watermark flag full", 1, wm_hit);
    $display("test sources done");
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      {oth, conv_ready, int_pin_sel, fifo_enable} <= {2'b11, i[1:0], i[2]};
      tick(1);
      if (i[2]) cmp("clock pin input", i[1:0] != 2'h1, clock_input_active);
      if (i[1:0] == 2'h3) cmp("unused code", 0, {pins.dedicated_irq, pins.clock_pin_irq_oe});
    end
    $display("test routing done");
    fifo_enable <= 1'b0;
    ctrl(7'h10);
    cmp("disabled write", 0, clr_seen);
    @(posedge clock);
    {fifo_enable, frame_pin_flush_enable} <= 2'b11;
    @(posedge clock);
    frame_sync_n <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      tick(1);
      if (fifo_clear && sequencer_restart) seen = 1'b1;
    end
    cmp("sync flush", 1, seen);
    $display("test clearing done");
    print_verdict();
  end
endmodule
